// File: testbench/pin_model.sv
// partner model: event pins and gate inputs of both timers
// assumes the bench calls its tasks; pins idle high, gates idle low
`timescale 1ns/1ps
module pin_model (
  // clock
  input  wire logic mclk_i,
  // pins toward the block
  output logic      event_pin_a_o,
  output logic      event_pin_b_o,
  output logic      gate_a_o,
  output logic      gate_b_o
);
  initial begin
    event_pin_a_o = 1'b1;
    event_pin_b_o = 1'b1;
    gate_a_o      = 1'b0;
    gate_b_o      = 1'b0;
  end

  task automatic pulse(input bit sel, input int n);
    repeat (n) begin
      @(posedge mclk_i);
      if (sel) begin
        event_pin_b_o <= 1'b0;
      end else begin
        event_pin_a_o <= 1'b0;
      end
      repeat (2) @(posedge mclk_i);
      if (sel) begin
        event_pin_b_o <= 1'b1;
      end else begin
        event_pin_a_o <= 1'b1;
      end
      @(posedge mclk_i);
    end
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic set_gate(input bit sel, input logic v);
    @(posedge mclk_i);
    if (sel) begin
      gate_b_o <= v;
    end else begin
      gate_a_o <= v;
    end
    repeat (6) @(posedge mclk_i);
  endtask
endmodule

// File: testbench/tb_top.sv
// testbench: register-port tests of the dual counter/timer
// assumes pin_model drives pins; register port never stalls
`timescale 1ns/1ps
module tb_top import timer_pkg::*;;
  logic       mclk = 1'b0;
  logic       resetn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr_en = 1'b0;
  logic       rd_en = 1'b0;
  logic [7:0] rdata;
  logic       pin_a, pin_b, gate_a, gate_b;
  logic       irq_a, irq_b, ovf_a, ovf_b;
  logic [7:0] v1, v2;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         ovf_b_cnt = 0;
  int         ovf_a_cnt = 0;
  int         n0;

  always #4 mclk = ~mclk;

  dual_counter_timer i_dut (
    .mclk_i(mclk), .resetn_i(resetn), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_en), .rd_i(rd_en), .rdata_o(rdata),
    .event_pin_a_i(pin_a), .event_pin_b_i(pin_b),
    .ext_gate_input_a_i(gate_a), .ext_gate_input_b_i(gate_b),
    .irq_a_o(irq_a), .irq_b_o(irq_b),
    .overflow_pulse_a_o(ovf_a), .overflow_pulse_b_o(ovf_b)
  );

  pin_model i_pins (
    .mclk_i(mclk), .event_pin_a_o(pin_a), .event_pin_b_o(pin_b),
    .gate_a_o(gate_a), .gate_b_o(gate_b)
  );

  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (ovf_b === 1'b1) ovf_b_cnt <= ovf_b_cnt + 1;
    if (ovf_a === 1'b1) ovf_a_cnt <= ovf_a_cnt + 1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rreg(a, v);
    check(v, e);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  initial begin
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 9; i++) rchk(i[3:0], 8'h00);
    wreg(4'hF, 8'hFF);
    rchk(4'hF, 8'h00);
    wreg(ADDR_LOW_A, 8'h5A);
    wreg(ADDR_HIGH_A, 8'hA5);
    wreg(ADDR_LOW_B, 8'h3C);
    wreg(ADDR_HIGH_B, 8'hC3);
    rchk(ADDR_LOW_A, 8'h5A);
    rchk(ADDR_HIGH_A, 8'hA5);
    rchk(ADDR_LOW_B, 8'h3C);
    rchk(ADDR_HIGH_B, 8'hC3);
    done("reset_and_bytes");
    // 16-bit counter on pin a
    n0 = ovf_a_cnt;
    wreg(ADDR_MODE, 8'h05);
    wreg(ADDR_HIGH_A, 8'hFF);
    wreg(ADDR_LOW_A, 8'hFE);
    wreg(ADDR_IRQ_EN, 8'h02);
    wreg(ADDR_RUN_FLAG, 8'h10);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_A, 8'hFF);
    wreg(ADDR_RUN_FLAG, 8'h00);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_A, 8'hFF);
    wreg(ADDR_RUN_FLAG, 8'h10);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_A, 8'h00);
    rchk(ADDR_HIGH_A, 8'h00);
    rchk(ADDR_RUN_FLAG, 8'h30);
    check({7'h00, (ovf_a_cnt - n0) == 1}, 8'h01);
    check({7'h00, irq_a}, 8'h01);
    wreg(ADDR_IRQ_EN, 8'h00);
    repeat (2) @(posedge mclk);
    check({7'h00, irq_a}, 8'h00);
    done("mode16");
    // 13-bit counter wrap
    wreg(ADDR_MODE, 8'h04);
    wreg(ADDR_HIGH_A, 8'hFF);
    wreg(ADDR_LOW_A, 8'h1F);
    wreg(ADDR_RUN_FLAG, 8'h10);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_HIGH_A, 8'h00);
    rreg(ADDR_LOW_A, v1);
    check(v1 & 8'h1F, 8'h00);
    rchk(ADDR_RUN_FLAG, 8'h30);
    done("mode13");
    // 8-bit auto-reload
    n0 = ovf_a_cnt;
    wreg(ADDR_MODE, 8'h06);
    wreg(ADDR_HIGH_A, 8'h80);
    wreg(ADDR_LOW_A, 8'hFE);
    wreg(ADDR_RUN_FLAG, 8'h10);
    i_pins.pulse(1'b0, 2);
    rchk(ADDR_LOW_A, 8'h80);
    rchk(ADDR_HIGH_A, 8'h80);
    rchk(ADDR_RUN_FLAG, 8'h30);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_A, 8'h81);
    check({7'h00, (ovf_a_cnt - n0) == 1}, 8'h01);
    done("reload");
    // gate on timer a
    wreg(ADDR_MODE, 8'h0D);
    wreg(ADDR_EXT_CFG, 8'h08);
    wreg(ADDR_LOW_A, 8'h00);
    wreg(ADDR_RUN_FLAG, 8'h10);
    i_pins.pulse(1'b0, 2);
    rchk(ADDR_LOW_A, 8'h00);
    i_pins.set_gate(1'b0, 1'b1);
    i_pins.pulse(1'b0, 2);
    rchk(ADDR_LOW_A, 8'h02);
    wreg(ADDR_EXT_CFG, 8'h00);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_A, 8'h02);
    done("gate_a");
    // timer b with its own gate
    wreg(ADDR_RUN_FLAG, 8'h00);
    wreg(ADDR_MODE, 8'hD0);
    wreg(ADDR_EXT_CFG, 8'h80);
    i_pins.set_gate(1'b1, 1'b1);
    wreg(ADDR_LOW_B, 8'hFF);
    wreg(ADDR_HIGH_B, 8'hFF);
    wreg(ADDR_IRQ_EN, 8'h08);
    wreg(ADDR_RUN_FLAG, 8'h40);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_B, 8'hFF);
    i_pins.pulse(1'b1, 1);
    rchk(ADDR_LOW_B, 8'h00);
    rchk(ADDR_HIGH_B, 8'h00);
    rchk(ADDR_RUN_FLAG, 8'hC0);
    check({7'h00, irq_b}, 8'h01);
    done("timer_b");
    // split mode
    wreg(ADDR_RUN_FLAG, 8'h00);
    wreg(ADDR_MODE, 8'h37);
    wreg(ADDR_CLK_SRC, 8'h18);
    wreg(ADDR_LOW_A, 8'h00);
    wreg(ADDR_HIGH_A, 8'h00);
    wreg(ADDR_LOW_B, 8'h00);
    wreg(ADDR_RUN_FLAG, 8'h50);
    i_pins.pulse(1'b0, 1);
    rchk(ADDR_LOW_A, 8'h01);
    rreg(ADDR_HIGH_A, v1);
    rreg(ADDR_HIGH_A, v2);
    check(v2 - v1, 8'h02);
    repeat (300) @(posedge mclk);
    rreg(ADDR_RUN_FLAG, v1);
    check(v1 & 8'h80, 8'h80);
    check({7'h00, irq_b}, 8'h01);
    rchk(ADDR_LOW_B, 8'h00);
    wreg(ADDR_MODE, 8'h27);
    wreg(ADDR_HIGH_B, 8'hFF);
    wreg(ADDR_LOW_B, 8'hFE);
    wreg(ADDR_RUN_FLAG, 8'h00);
    n0 = ovf_b_cnt;
    repeat (20) @(posedge mclk);
    check({7'h00, (ovf_b_cnt - n0) >= 10}, 8'h01);
    rchk(ADDR_RUN_FLAG, 8'h00);
    check({7'h00, irq_b}, 8'h00);
    done("split");
    // prescaled clock at divide by four
    wreg(ADDR_MODE, 8'h01);
    wreg(ADDR_CLK_SRC, 8'h01);
    wreg(ADDR_LOW_A, 8'h00);
    wreg(ADDR_HIGH_A, 8'h00);
    wreg(ADDR_RUN_FLAG, 8'h10);
    repeat (38) @(posedge mclk);
    wreg(ADDR_RUN_FLAG, 8'h00);
    rreg(ADDR_LOW_A, v1);
    check({7'h00, v1 >= 8'h08 && v1 <= 8'h0C}, 8'h01);
    done("prescale");
    // system clock, one count per cycle
    wreg(ADDR_CLK_SRC, 8'h08);
    wreg(ADDR_LOW_A, 8'h00);
    wreg(ADDR_RUN_FLAG, 8'h10);
    repeat (6) @(posedge mclk);
    wreg(ADDR_RUN_FLAG, 8'h00);
    rchk(ADDR_LOW_A, 8'h08);
    done("sysclk");
    close_out();
  end
endmodule

// File: verilog/dual_counter_timer.sv
// dual legacy counter/timer with register port
// assumes software owns the register port and pins are asynchronous
//
// Contract
// R1: two timers, 16-bit count, byte access
// R2: counter mode counts event pin falls
// R3: events counted up to quarter clock
// R4: event source holds level two cycles
// R5: four modes per timer, independently selected
// R6: 13-bit mode: high byte, low five
// R7: 13-bit wrap sets flag, irq request
// R8: select bit picks pin or internal
// R9: system clock or prescaled clock
// R10: count needs run and gate condition
// R11: run does not clear count
// R12: software loads count before run
// R13: second timer mirrors first, own gate
// R14: 16-bit mode uses all bits
// R15: reload mode: low counts, reloads high
// R16: software presets low byte first
// R17: split: low byte uses first controls
// R18: split: high byte, second run, flag
// R19: split: second timer no flag, pulse
// R20: split: second timer stops in mode3
// R21: irq only when enable bit set
// R22: inputs sampled, fall on high-low
`timescale 1ns/1ps
module dual_counter_timer import timer_pkg::*; (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // pins
  input  wire logic              event_pin_a_i,
  input  wire logic              event_pin_b_i,
  input  wire logic              ext_gate_input_a_i,
  input  wire logic              ext_gate_input_b_i,
  // requests and overflow pulses
  output logic                   irq_a_o,
  output logic                   irq_b_o,
  output logic                   overflow_pulse_a_o,
  output logic                   overflow_pulse_b_o
);

  logic        run_a_q;
  logic        run_b_q;
  logic        flag_a_q;
  logic        flag_b_q;
  logic [7:0]  counter_mode_control_q;
  logic [7:0]  clock_source_control_q;
  logic [7:0]  ext_input_config_q;
  logic [7:0]  interrupt_enable_reg_q;
  logic [7:0]  lo_a_q;
  logic [7:0]  hi_a_q;
  logic [7:0]  lo_b_q;
  logic [7:0]  hi_b_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rmux;
  logic        irq_a_q;
  logic        irq_b_q;
  logic        ovp_a_q;
  logic        ovp_b_q;
  logic [3:0]  pin_lvl;
  logic [3:0]  pin_fall;
  logic        pre_tick;
  logic [1:0]  mode_a;
  logic [1:0]  mode_b;
  logic        split;
  logic        gate_ok_a;
  logic        gate_ok_b;
  logic        int_a;
  logic        int_b;
  logic        tick_a;
  logic        tick_ah;
  logic        tick_b;
  logic [16:0] nxt_a;
  logic [16:0] nxt_b;
  logic        ovf_a;
  logic        ovf_ah;
  logic        ovf_b;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic        wr_ctrl;
  logic        wr_cnt;

  // R6 R15: mode step, overflow on top
  function automatic logic [16:0] step(input logic [1:0] m, input logic [15:0] c);
    logic [12:0] c13;
    logic [15:0] n;
    logic        o;
    c13 = 13'h0000;
    n   = c;
    o   = 1'b0;
    unique case (m)
      MODE_13: begin
        c13 = {c[15:8], c[4:0]} + 13'h0001;
        n   = {c13[12:5], c[7:5], c13[4:0]};
        o   = &{c[15:8], c[4:0]};
      end
      MODE_16: begin
        n = c + 16'h0001;
        o = &c;
      end
      MODE_RELOAD: begin
        n = {c[15:8], (&c[7:0]) ? c[15:8] : c[7:0] + 8'h01};
        o = &c[7:0];
      end
      MODE_SPLIT: begin
        n = {c[15:8], c[7:0] + 8'h01};
        o = &c[7:0];
      end
    endcase
    return {o, n};
  endfunction

  // R22: pin sampling
  in_sync #(.N(4)) u_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .in_i     ({ext_gate_input_b_i, ext_gate_input_a_i, event_pin_b_i, event_pin_a_i}),
    .level_o  (pin_lvl),
    .fall_o   (pin_fall)
  );

  presc_tick u_presc (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .sel_i    (clock_source_control_q[PRESCALE_LSB +: 2]),
    .tick_o   (pre_tick)
  );

  assign mode_a  = counter_mode_control_q[MODE_A_LSB +: 2];
  assign mode_b  = counter_mode_control_q[MODE_B_LSB +: 2];
  assign split   = (mode_a == MODE_SPLIT);
  assign cnt_a   = {hi_a_q, lo_a_q};
  assign cnt_b   = {hi_b_q, lo_b_q};
  assign wr_ctrl = wr_i & (addr_i == ADDR_RUN_FLAG);
  assign wr_cnt  = wr_i & (addr_i >= ADDR_LOW_A) & (addr_i <= ADDR_HIGH_B);

  // R10: gate passes at configured polarity
  assign gate_ok_a = ~counter_mode_control_q[GATE_A_BIT]
                   | (pin_lvl[2] == ext_input_config_q[POL_A_BIT]);
  // R13: second gate, own polarity
  assign gate_ok_b = ~counter_mode_control_q[GATE_B_BIT]
                   | (pin_lvl[3] == ext_input_config_q[POL_B_BIT]);

  // R9: system or prescaled clock
  assign int_a = clock_source_control_q[SYSCLK_A_BIT] | pre_tick;
  assign int_b = clock_source_control_q[SYSCLK_B_BIT] | pre_tick;

  // R2 R3 R8: pin falls or internal
  assign tick_a = run_a_q & gate_ok_a
                & (counter_mode_control_q[CT_A_BIT] ? pin_fall[0] : int_a);
  // R18: split high byte on second run
  assign tick_ah = split & run_b_q & int_a;
  // R20: second timer run by its mode
  assign tick_b = (mode_b != MODE_SPLIT) & (split ? int_b : run_b_q & gate_ok_b
                & (counter_mode_control_q[CT_B_BIT] ? pin_fall[1] : int_b));

  assign nxt_a  = step(mode_a, cnt_a);
  assign nxt_b  = step(mode_b, cnt_b);
  assign ovf_a  = tick_a & nxt_a[16];
  assign ovf_ah = tick_ah & (&hi_a_q);
  assign ovf_b  = tick_b & nxt_b[16];

  // R5 R11: modes, run keeps count
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      counter_mode_control_q <= REG_RESET;
      clock_source_control_q <= REG_RESET;
      ext_input_config_q     <= REG_RESET;
      interrupt_enable_reg_q <= REG_RESET;
      run_a_q                <= 1'b0;
      run_b_q                <= 1'b0;
    end else if (wr_i) begin
      unique case (addr_i)
        ADDR_MODE:    counter_mode_control_q <= wdata_i;
        ADDR_CLK_SRC: clock_source_control_q <= wdata_i;
        ADDR_EXT_CFG: ext_input_config_q     <= wdata_i;
        ADDR_IRQ_EN:  interrupt_enable_reg_q <= wdata_i;
        ADDR_RUN_FLAG: begin
          run_a_q <= wdata_i[RUN_A_BIT];
          run_b_q <= wdata_i[RUN_B_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // R7: overflow flags, set beats clear
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
    end else begin
      flag_a_q <= ovf_a | (wr_ctrl ? wdata_i[FLAG_A_BIT] : flag_a_q);
      // R19: split mode second timer sets no flag
      flag_b_q <= (split ? ovf_ah : ovf_b)
                | (wr_ctrl ? wdata_i[FLAG_B_BIT] : flag_b_q);
    end
  end

  // R1: first count, byte writes win
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      lo_a_q <= REG_RESET;
      hi_a_q <= REG_RESET;
    end else begin
      // R14: increment in selected mode
      if (tick_a) begin
        {hi_a_q, lo_a_q} <= nxt_a[15:0];
      end
      // R18: split high byte independent
      if (tick_ah) begin
        hi_a_q <= hi_a_q + 8'h01;
      end
      if (wr_i && addr_i == ADDR_LOW_A) begin
        lo_a_q <= wdata_i;
      end
      if (wr_i && addr_i == ADDR_HIGH_A) begin
        hi_a_q <= wdata_i;
      end
    end
  end

  // R13: second count, same behaviour
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      lo_b_q <= REG_RESET;
      hi_b_q <= REG_RESET;
    end else begin
      if (tick_b) begin
        {hi_b_q, lo_b_q} <= nxt_b[15:0];
      end
      if (wr_i && addr_i == ADDR_LOW_B) begin
        lo_b_q <= wdata_i;
      end
      if (wr_i && addr_i == ADDR_HIGH_B) begin
        hi_b_q <= wdata_i;
      end
    end
  end

  // R21: requests gated by enables
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
      ovp_a_q <= 1'b0;
      ovp_b_q <= 1'b0;
    end else begin
      irq_a_q <= flag_a_q & interrupt_enable_reg_q[IRQEN_A_BIT];
      irq_b_q <= flag_b_q & interrupt_enable_reg_q[IRQEN_B_BIT];
      ovp_a_q <= ovf_a;
      // R19: overflow still reaches consumers
      ovp_b_q <= ovf_b;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    unique case (addr_i)
      ADDR_RUN_FLAG: rmux = {flag_b_q, run_b_q, flag_a_q, run_a_q, 4'h0};
      ADDR_MODE:     rmux = counter_mode_control_q;
      ADDR_CLK_SRC:  rmux = clock_source_control_q;
      ADDR_EXT_CFG:  rmux = ext_input_config_q;
      ADDR_IRQ_EN:   rmux = interrupt_enable_reg_q;
      ADDR_LOW_A:    rmux = lo_a_q;
      ADDR_HIGH_A:   rmux = hi_a_q;
      ADDR_LOW_B:    rmux = lo_b_q;
      ADDR_HIGH_B:   rmux = hi_b_q;
      default:       rmux = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_i ? rmux : 8'h00;
    end
  end

  assign rdata_o            = rdata_q;
  assign irq_a_o            = irq_a_q;
  assign irq_b_o            = irq_b_q;
  assign overflow_pulse_a_o = ovp_a_q;
  assign overflow_pulse_b_o = ovp_b_q;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_read_byte;
    rd_i && addr_i == ADDR_LOW_A |=> rdata_o == $past(lo_a_q) ##1 rdata_o == 8'h00 || $past(rd_i);
  endproperty
  a_read_byte: assert property (p_read_byte) else $error("low byte read wrong"); // R1

  property p_ext_inc;
    mode_a == MODE_16 && run_a_q && gate_ok_a && counter_mode_control_q[CT_A_BIT]
      && pin_fall[0] && !wr_cnt |=> cnt_a == $past(cnt_a) + 16'h0001;
  endproperty
  a_ext_inc: assert property (p_ext_inc) else $error("event fall not counted"); // R2

  property p_sys_inc;
    (mode_a == MODE_16 && run_a_q && gate_ok_a && !counter_mode_control_q[CT_A_BIT]
      && clock_source_control_q[SYSCLK_A_BIT] && !wr_i) [*2] |=> cnt_a == $past(cnt_a, 2) + 16'h2;
  endproperty
  a_sys_inc: assert property (p_sys_inc) else $error("system clock count wrong"); // R9

  property p_wrap13;
    mode_a == MODE_13 && tick_a && (&hi_a_q) && (&lo_a_q[4:0]) && !wr_i
      |=> flag_a_q && hi_a_q == 8'h00 && lo_a_q[4:0] == 5'h00;
  endproperty
  a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong"); // R7

  property p_reload;
    mode_a == MODE_RELOAD && tick_a && (&lo_a_q) && !wr_i
      |=> lo_a_q == $past(hi_a_q) && hi_a_q == $past(hi_a_q) && flag_a_q;
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload wrong"); // R15

  property p_run_off;
    !run_a_q && !split && !wr_cnt |=> $stable(cnt_a);
  endproperty
  a_run_off: assert property (p_run_off) else $error("counted while stopped"); // R10

  property p_gate_closed;
    counter_mode_control_q[GATE_A_BIT] && pin_lvl[2] != ext_input_config_q[POL_A_BIT]
      && !split && !wr_cnt |=> $stable(cnt_a);
  endproperty
  a_gate_closed: assert property (p_gate_closed) else $error("counted with gate closed"); // R10

  property p_run_keeps;
    wr_ctrl && !tick_a && !split |=> $stable(cnt_a);
  endproperty
  a_run_keeps: assert property (p_run_keeps) else $error("run write changed count"); // R11

  property p_split_hi;
    split && !run_b_q && !wr_cnt |=> $stable(hi_a_q);
  endproperty
  a_split_hi: assert property (p_split_hi) else $error("split high ran without run"); // R18

  property p_b_mode3;
    mode_b == MODE_SPLIT && !wr_cnt |=> $stable(cnt_b);
  endproperty
  a_b_mode3: assert property (p_b_mode3) else $error("second timer ran in mode 3"); // R20

  property p_b_noflag;
    split && ovf_b && !ovf_ah && !wr_ctrl |=> flag_b_q == $past(flag_b_q) && overflow_pulse_b_o;
  endproperty
  a_b_noflag: assert property (p_b_noflag) else $error("second flag set in split"); // R19

  property p_irq_gate;
    !interrupt_enable_reg_q[IRQEN_A_BIT] |=> !irq_a_o;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enable"); // R21

  property p_edge;
    pin_fall[0] |-> !pin_lvl[0] && $past(pin_lvl[0]);
  endproperty
  a_edge: assert property (p_edge) else $error("fall without high to low"); // R22

endmodule

// File: verilog/in_sync.sv
// pin sampler: three flops per input, level and falling-edge pulse
// assumes inputs are asynchronous to mclk_i
`timescale 1ns/1ps
module in_sync import timer_pkg::*; #(
  parameter int N = 4
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         resetn_i,
  // pins and results
  input  wire logic [N-1:0] in_i,
  output logic      [N-1:0] level_o,
  output logic      [N-1:0] fall_o
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      logic fall_q;
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
        end else begin
          s1_q <= in_i[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // R22: agreed level, falling edge
      always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
          lvl_q  <= 1'b1;
          fall_q <= 1'b0;
        end else begin
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
          fall_q <= (s2_q == s3_q) & lvl_q & ~s3_q;
        end
      end
      assign level_o[g] = lvl_q;
      assign fall_o[g]  = fall_q;
    end
  endgenerate

endmodule

// File: verilog/presc_tick.sv
// prescaled clock: one-cycle enable at the selected divide ratio
// assumes a single system clock
`timescale 1ns/1ps
module presc_tick import timer_pkg::*; (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       resetn_i,
  // ratio select and enable out
  input  wire logic [1:0] sel_i,
  output logic            tick_o
);

  logic [5:0] div;
  logic [5:0] cnt_q;
  logic       tick_q;

  always_comb begin
    unique case (sel_i)
      2'h0: div = DIV_SEL0;
      2'h1: div = DIV_SEL1;
      2'h2: div = DIV_SEL2;
      2'h3: div = DIV_SEL3;
    endcase
  end

  // R9: prescaled clock enable
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      cnt_q  <= 6'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (cnt_q >= div - 6'h01);
      if (cnt_q >= div - 6'h01) begin
        cnt_q <= 6'h00;
      end else begin
        cnt_q <= cnt_q + 6'h01;
      end
    end
  end

  assign tick_o = tick_q;

endmodule

// File: verilog/timer_pkg.sv
// constants for the dual counter/timer block
// assumes an 8-bit register port and a single system clock
package timer_pkg;

  // register port widths
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [3:0] ADDR_RUN_FLAG  = 4'h0;
  localparam logic [3:0] ADDR_MODE      = 4'h1;
  localparam logic [3:0] ADDR_CLK_SRC   = 4'h2;
  localparam logic [3:0] ADDR_EXT_CFG   = 4'h3;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h4;
  localparam logic [3:0] ADDR_LOW_A     = 4'h5;
  localparam logic [3:0] ADDR_HIGH_A    = 4'h6;
  localparam logic [3:0] ADDR_LOW_B     = 4'h7;
  localparam logic [3:0] ADDR_HIGH_B    = 4'h8;

  // run_and_flag_control fields
  localparam int FLAG_B_BIT = 7;
  localparam int RUN_B_BIT  = 6;
  localparam int FLAG_A_BIT = 5;
  localparam int RUN_A_BIT  = 4;

  // counter_mode_control fields
  localparam int MODE_A_LSB = 0;
  localparam int CT_A_BIT   = 2;
  localparam int GATE_A_BIT = 3;
  localparam int MODE_B_LSB = 4;
  localparam int CT_B_BIT   = 6;
  localparam int GATE_B_BIT = 7;

  // clock_source_control fields
  localparam int PRESCALE_LSB = 0;
  localparam int SYSCLK_A_BIT = 3;
  localparam int SYSCLK_B_BIT = 4;

  // ext_input_config and interrupt_enable_reg fields
  localparam int POL_A_BIT   = 3;
  localparam int POL_B_BIT   = 7;
  localparam int IRQEN_A_BIT = 1;
  localparam int IRQEN_B_BIT = 3;

  // reset values
  localparam logic [7:0] REG_RESET = 8'h00;

  // operating modes
  localparam logic [1:0] MODE_13     = 2'h0;
  localparam logic [1:0] MODE_16     = 2'h1;
  localparam logic [1:0] MODE_RELOAD = 2'h2;
  localparam logic [1:0] MODE_SPLIT  = 2'h3;

  // prescaler divide ratios, indexed by prescale_select
  localparam logic [5:0] DIV_SEL0 = 6'h0C;
  localparam logic [5:0] DIV_SEL1 = 6'h04;
  localparam logic [5:0] DIV_SEL2 = 6'h30;
  localparam logic [5:0] DIV_SEL3 = 6'h08;

endpackage
